//--- core/upc_top.sv
// level-5 and level-4 paging structure caches with an AXI4-Lite control slave
`timescale 1ns/1ns
`default_nettype none
`include "upc_cfg.svh"

module upc_top #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // lookup from the page walker
  input  wire logic                  lookup_valid,
  input  wire upc_pkg::upc_lookup_t  lookup_req,
  output logic                       result_valid,
  output upc_pkg::upc_result_t       result,
  // fill from the page walker
  input  wire logic                  fill_valid,
  input  wire upc_pkg::upc_fill_t    fill_req,
  output logic                       fill_ready,
  output logic                       fill_done,
  output logic                       fill_alloc,
  // accessed flag updates towards memory
  output logic                       upd_valid,
  output upc_pkg::upc_update_t       upd,
  input  wire logic                  upd_ready,
  // invalidation
  input  wire logic                  invalidate
);

  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("upc_top: DEPTH must be a power of two from 2 to 128");
    end
  endgenerate

  // ====================================================================
  // helpers
  function automatic logic [17:0] tag_of(input logic lvl4, input upc_pkg::upc_kind_t kind,
                                         input logic five, input logic [56:0] ia,
                                         input logic [5:0] gaw);
    logic [56:0] m;
    m = ia;
    if (kind == upc_pkg::UPC_SECOND) begin
      m = ia & ((57'h1 << (7'(gaw) + 7'h1)) - 57'h1);
    end else if (!five) begin
      m = ia & ((57'h1 << (`UPC_FOUR_TOP + 1)) - 57'h1);
    end
    m = lvl4 ? (m >> `UPC_L4_LO) : (m >> `UPC_L5_LO);
    return m[17:0];
  endfunction : tag_of

  function automatic logic both_and(input logic inc5, input logic b5, input logic b4,
                                    input logic inc4);
    return (~inc5 | b5) & (~inc4 | b4);
  endfunction : both_and

  function automatic logic [7:0] count_valid(input upc_pkg::upc_entry_t c [DEPTH]);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < DEPTH; i++) begin
      n = n + {7'h00, c[i].valid};
    end
    return n;
  endfunction : count_valid

  // ====================================================================
  // control registers, entry arrays and allocation pointers
  logic [31:0]          ctrl_r;
  logic [15:0]          alloc_cnt_r;
  logic [15:0]          refuse_cnt_r;
  logic [31:0]          hit_cnt_r;
  upc_pkg::upc_entry_t  c5_r [DEPTH];
  upc_pkg::upc_entry_t  c4_r [DEPTH];
  logic [PW-1:0]        ptr5_r;
  logic [PW-1:0]        ptr4_r;

  wire       cfg_five  = ctrl_r[`UPC_CTRL_FIVE];
  wire       cfg_nx    = ctrl_r[`UPC_CTRL_NX];
  wire       cfg_ssx   = ctrl_r[`UPC_CTRL_SSX];
  wire       cfg_xae   = ctrl_r[`UPC_CTRL_XAE];
  wire       cfg_cmode = ctrl_r[`UPC_CTRL_CMODE];
  wire [5:0] cfg_gaw   = ctrl_r[`UPC_CTRL_GAW_LO +: 6];
  wire       nest_mode = (ctrl_r[`UPC_CTRL_TMODE_LO +: 2] == `UPC_TMODE_SCALABLE)
                         & ctrl_r[`UPC_CTRL_NEST];

  // ====================================================================
  // axi4-lite slave: address and data taken in either order
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire do_wr  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire ar_hs  = s_axi_arvalid & s_axi_arready;
  wire wr_ctl = do_wr & (awaddr_r == `UPC_OFS_CTRL);
  wire wr_hit = (awaddr_r == `UPC_OFS_CTRL) | (awaddr_r == `UPC_OFS_LEVEL)
                | (awaddr_r == `UPC_OFS_FILLS) | (awaddr_r == `UPC_OFS_HITS);
  wire sw_inv = wr_ctl & wstrb_r[1] & wdata_r[`UPC_CTRL_INVAL];

  wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] ctrl_nxt  = (ctrl_r & ~(strb_mask & `UPC_CTRL_WMASK))
                          | (wdata_r & strb_mask & `UPC_CTRL_WMASK);

  wire [31:0] level_val = {16'h0000, count_valid(c4_r), count_valid(c5_r)};
  wire        rd_hit    = (s_axi_araddr == `UPC_OFS_CTRL) | (s_axi_araddr == `UPC_OFS_LEVEL)
                          | (s_axi_araddr == `UPC_OFS_FILLS) | (s_axi_araddr == `UPC_OFS_HITS);
  wire [31:0] rd_val    = (s_axi_araddr == `UPC_OFS_CTRL)  ? ctrl_r :
                          (s_axi_araddr == `UPC_OFS_LEVEL) ? level_val :
                          (s_axi_araddr == `UPC_OFS_FILLS) ? {refuse_cnt_r, alloc_cnt_r} :
                          (s_axi_araddr == `UPC_OFS_HITS)  ? hit_cnt_r : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `UPC_CTRL_RST;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        awaddr_r      <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // the invalidate bit never stores; it only fires a pulse
      if (wr_ctl) begin
        ctrl_r <= ctrl_nxt;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? 2'h0 : 2'h3;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ====================================================================
  // lookup
  wire [17:0] lk_tag5 = tag_of(1'b0, lookup_req.kind, lookup_req.five, lookup_req.iaddr, cfg_gaw);
  wire [17:0] lk_tag4 = tag_of(1'b1, lookup_req.kind, lookup_req.five, lookup_req.iaddr, cfg_gaw);
  // entry-address lookups exist only for nested walks in scalable mode
  wire lk_ok  = ~lookup_req.from_entry
                | (nest_mode & (lookup_req.kind == upc_pkg::UPC_SECOND));
  wire lk_ok5 = lk_ok & cfg_five & lookup_req.five;

  upc_pkg::upc_result_t lk_res;

  always_comb begin
    lk_res = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (lk_ok5 && c5_r[i].valid && c5_r[i].kind == lookup_req.kind
          && c5_r[i].tag == lk_tag5) begin
        lk_res.hit5 = 1'b1;
        lk_res.ent5 = c5_r[i];
      end
      if (lk_ok && c4_r[i].valid && c4_r[i].kind == lookup_req.kind
          && c4_r[i].five == lookup_req.five && c4_r[i].tag == lk_tag4) begin
        lk_res.hit4 = 1'b1;
        lk_res.ent4 = c4_r[i];
      end
    end
  end

  // a hit lets the walker skip the memory read of the cached entries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_valid <= 1'b0;
      result       <= '0;
      hit_cnt_r    <= 32'h0000_0000;
    end else begin
      result_valid <= lookup_valid;
      if (lookup_valid) begin
        result <= lk_res;
      end
      if (lookup_valid && (lk_res.hit5 || lk_res.hit4)) begin
        hit_cnt_r <= hit_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ====================================================================
  // fill: checks, accessed flag updates, allocation
  upc_pkg::upc_state_t state_r;
  upc_pkg::upc_fill_t  fr;

  wire sl_kind = (fr.kind == upc_pkg::UPC_SECOND);
  wire nested  = (fr.kind == upc_pkg::UPC_NESTED);
  wire inc5    = ~fr.lvl4 | fr.five;
  wire inc4    = fr.lvl4;

  wire fl_ok5 = fr.e5[`UPC_E_P] & ~|(fr.e5 & `UPC_FL_RSV_MASK);
  wire fl_ok4 = fr.e4[`UPC_E_P] & ~|(fr.e4 & `UPC_FL_RSV_MASK);
  wire sl_ok5 = (fr.e5[`UPC_S_R] | fr.e5[`UPC_S_W]) & ~|(fr.e5 & `UPC_SL_RSV_MASK);
  wire sl_ok4 = (fr.e4[`UPC_S_R] | fr.e4[`UPC_S_W]) & ~|(fr.e4 & `UPC_SL_RSV_MASK);

  wire need5 = ~sl_kind & inc5
               & (~fr.e5[`UPC_E_A] | (cfg_xae & ~fr.e5[`UPC_E_XA]));
  wire need4 = ~sl_kind & inc4
               & (~fr.e4[`UPC_E_A] | (cfg_xae & ~fr.e4[`UPC_E_XA]));

  wire lvl_ok  = fr.lvl4 | (cfg_five & fr.five);
  wire fl_ok   = both_and(inc5, fl_ok5, fl_ok4, inc4);
  wire rd_ok   = both_and(inc5, fr.ss_rd5, fr.ss_rd4, inc4);
  wire wrp_ok  = (~need5 | fr.ss_wr5) & (~need4 | fr.ss_wr4);
  wire sl_ok   = cfg_cmode | both_and(inc5, sl_ok5, sl_ok4, inc4);
  wire fill_ok = lvl_ok & (sl_kind ? sl_ok : (fl_ok & (~nested | (rd_ok & wrp_ok))));

  wire [63:0] set5 = (64'h1 << `UPC_E_A) | ({63'h0, cfg_xae} << `UPC_E_XA);

  // merged rights; level-5 bits drop out under 4-level paging
  wire [63:0] eo    = fr.lvl4 ? fr.e4 : fr.e5;
  wire rw_and = both_and(inc5, fr.e5[`UPC_E_RW], fr.e4[`UPC_E_RW], inc4);
  wire us_and = both_and(inc5, fr.e5[`UPC_E_US], fr.e4[`UPC_E_US], inc4);
  wire nx_or  = cfg_nx & ((inc5 & fr.e5[`UPC_E_NX]) | (inc4 & fr.e4[`UPC_E_NX]));
  wire r_and  = both_and(inc5, fr.e5[`UPC_S_R], fr.e4[`UPC_S_R], inc4);
  wire w_and  = both_and(inc5, fr.e5[`UPC_S_W], fr.e4[`UPC_S_W], inc4);
  wire x_and  = ~cfg_ssx | both_and(inc5, fr.e5[`UPC_S_X], fr.e4[`UPC_S_X], inc4);
  wire ss_x   = ~cfg_ssx | fr.ss_x;

  upc_pkg::upc_entry_t new_ent;

  always_comb begin
    new_ent       = '0;
    new_ent.valid = 1'b1;
    new_ent.kind  = fr.kind;
    new_ent.five  = fr.five;
    new_ent.tag   = tag_of(fr.lvl4, fr.kind, fr.five, fr.iaddr, cfg_gaw);
    unique case (fr.kind)
      upc_pkg::UPC_SECOND: begin
        // execute kept inverted in the nx field so all kinds share one layout
        new_ent.tab = eo[51:12];
        new_ent.rd  = r_and;
        new_ent.wr  = w_and;
        new_ent.us  = 1'b1;
        new_ent.nx  = ~x_and;
      end
      upc_pkg::UPC_NESTED: begin
        new_ent.tab = fr.ss_tab;
        new_ent.rd  = 1'b1;
        new_ent.wr  = rw_and & fr.ss_w;
        new_ent.us  = us_and;
        new_ent.nx  = nx_or | ~ss_x;
      end
      default: begin
        new_ent.tab   = eo[51:12];
        new_ent.rd    = 1'b1;
        new_ent.wr    = rw_and;
        new_ent.us    = us_and;
        new_ent.nx    = nx_or;
        new_ent.cdis  = eo[`UPC_E_CDIS];
        new_ent.wthru = eo[`UPC_E_WTHRU];
      end
    endcase
  end

  wire inval   = invalidate | sw_inv;
  wire upd_hs  = upd_valid & upd_ready;
  wire fill_hs = fill_valid & fill_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= upc_pkg::ST_IDLE;
      fr           <= '0;
      fill_ready   <= 1'b1;
      fill_done    <= 1'b0;
      fill_alloc   <= 1'b0;
      upd_valid    <= 1'b0;
      upd          <= '0;
      alloc_cnt_r  <= 16'h0000;
      refuse_cnt_r <= 16'h0000;
    end else begin
      fill_done  <= 1'b0;
      fill_alloc <= 1'b0;
      unique case (state_r)
        upc_pkg::ST_IDLE: begin
          if (fill_hs) begin
            fr         <= fill_req;
            fill_ready <= 1'b0;
            state_r    <= upc_pkg::ST_CHECK;
          end
        end
        upc_pkg::ST_CHECK: begin
          if (!fill_ok) begin
            fill_done    <= 1'b1;
            fill_ready   <= 1'b1;
            refuse_cnt_r <= refuse_cnt_r + 16'h0001;
            state_r      <= upc_pkg::ST_IDLE;
          end else if (need5) begin
            upd_valid <= 1'b1;
            upd       <= '{addr: fr.a5, set_bits: set5};
            state_r   <= upc_pkg::ST_UPD5;
          end else if (need4) begin
            upd_valid <= 1'b1;
            upd       <= '{addr: fr.a4, set_bits: set5};
            state_r   <= upc_pkg::ST_UPD4;
          end else begin
            state_r <= upc_pkg::ST_ALLOC;
          end
        end
        upc_pkg::ST_UPD5: begin
          if (upd_hs && need4) begin
            upd     <= '{addr: fr.a4, set_bits: set5};
            state_r <= upc_pkg::ST_UPD4;
          end else if (upd_hs) begin
            upd_valid <= 1'b0;
            state_r   <= upc_pkg::ST_ALLOC;
          end
        end
        upc_pkg::ST_UPD4: begin
          if (upd_hs) begin
            upd_valid <= 1'b0;
            state_r   <= upc_pkg::ST_ALLOC;
          end
        end
        upc_pkg::ST_ALLOC: begin
          // the referenced table is never inspected, so empty tables are cached too
          fill_done   <= 1'b1;
          fill_alloc  <= ~inval;
          fill_ready  <= 1'b1;
          alloc_cnt_r <= alloc_cnt_r + {15'h0000, ~inval};
          state_r     <= upc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ====================================================================
  // entry storage; entries stay as allocated until invalidated or overwritten when the pointer wraps, even if
  // memory changes underneath, and an allocation racing an invalidate is
  // dropped only in the invalidate cycle; a fill taken before it still allocates afterwards
  wire alloc = (state_r == upc_pkg::ST_ALLOC) & ~inval;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        c5_r[i] <= '0;
        c4_r[i] <= '0;
      end
      ptr5_r <= '0;
      ptr4_r <= '0;
    end else if (inval) begin
      for (int i = 0; i < DEPTH; i++) begin
        c5_r[i].valid <= 1'b0;
        c4_r[i].valid <= 1'b0;
      end
    end else if (alloc && fr.lvl4) begin
      c4_r[ptr4_r] <= new_ent;
      ptr4_r       <= ptr4_r + 1'b1;
    end else if (alloc) begin
      c5_r[ptr5_r] <= new_ent;
      ptr5_r       <= ptr5_r + 1'b1;
    end
  end

endmodule : upc_top

`default_nettype wire

//--- core/upc_cfg.svh
// offsets, field positions, reset values and address split points for the upper paging cache
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

// ====================================================================
// register byte offsets
`define UPC_OFS_CTRL        8'h00
`define UPC_OFS_LEVEL       8'h04
`define UPC_OFS_FILLS       8'h08
`define UPC_OFS_HITS        8'h0c

// ====================================================================
// control register fields
`define UPC_CTRL_FIVE       0
`define UPC_CTRL_NX         1
`define UPC_CTRL_SSX        2
`define UPC_CTRL_XAE        3
`define UPC_CTRL_CMODE      4
`define UPC_CTRL_NEST       5
`define UPC_CTRL_TMODE_LO   6
`define UPC_CTRL_INVAL      8
`define UPC_CTRL_GAW_LO     16
`define UPC_CTRL_RST        32'h002f_0000
`define UPC_CTRL_WMASK      32'h003f_00ff
`define UPC_TMODE_SCALABLE  2'h1

// ====================================================================
// paging entry fields
`define UPC_E_P             0
`define UPC_E_RW            1
`define UPC_E_US            2
`define UPC_E_WTHRU         3
`define UPC_E_CDIS          4
`define UPC_E_A             5
`define UPC_E_XA            10
`define UPC_E_NX            63
`define UPC_S_R             0
`define UPC_S_W             1
`define UPC_S_X             2
`define UPC_FL_RSV_MASK     64'h7ff0_0000_0000_0080
`define UPC_SL_RSV_MASK     64'h7ff0_0000_0000_0080

// ====================================================================
// address split points
`define UPC_L5_LO           48
`define UPC_L4_LO           39
`define UPC_FOUR_TOP        47

`endif

//--- core/upc_pkg.sv
// types shared by the upper paging cache
`default_nettype none

package upc_pkg;

  typedef enum logic [1:0] {UPC_FIRST, UPC_SECOND, UPC_NESTED} upc_kind_t;

  typedef struct packed {
    logic        valid;
    upc_kind_t   kind;
    logic        five;
    logic [17:0] tag;
    logic [39:0] tab;
    logic        rd;
    logic        wr;
    logic        us;
    logic        nx;
    logic        cdis;
    logic        wthru;
  } upc_entry_t;

  typedef struct packed {
    logic [56:0] iaddr;
    upc_kind_t   kind;
    logic        five;
    logic        from_entry;
  } upc_lookup_t;

  typedef struct packed {
    logic       hit5;
    upc_entry_t ent5;
    logic       hit4;
    upc_entry_t ent4;
  } upc_result_t;

  typedef struct packed {
    logic        lvl4;
    upc_kind_t   kind;
    logic        five;
    logic [56:0] iaddr;
    logic [63:0] e5;
    logic [63:0] e4;
    logic [51:0] a5;
    logic [51:0] a4;
    logic        ss_rd5;
    logic        ss_rd4;
    logic        ss_wr5;
    logic        ss_wr4;
    logic        ss_w;
    logic        ss_x;
    logic [39:0] ss_tab;
  } upc_fill_t;

  typedef struct packed {
    logic [51:0] addr;
    logic [63:0] set_bits;
  } upc_update_t;

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_UPD5, ST_UPD4, ST_ALLOC} upc_state_t;

endpackage : upc_pkg

`default_nettype wire

//--- test/upc_top_chk.sv
// port assertions for the upper paging cache
`timescale 1ns/1ns
`default_nettype none

module upc_top_chk (
  // clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // lookup and fill
  input wire logic                 lookup_valid,
  input wire upc_pkg::upc_lookup_t lookup_req,
  input wire logic                 result_valid,
  input wire upc_pkg::upc_result_t result,
  input wire logic                 fill_valid,
  input wire logic                 fill_ready,
  input wire logic                 fill_done,
  input wire logic                 fill_alloc,
  // updates and invalidation
  input wire logic                 upd_valid,
  input wire upc_pkg::upc_update_t upd,
  input wire logic                 upd_ready,
  input wire logic                 invalidate
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // fill handshake and invalidate-then-lookup steps
  sequence s_take;
    fill_valid && fill_ready;
  endsequence
  sequence s_clear;
    invalidate ##1 (lookup_valid && !invalidate);
  endsequence

  a_result_pulse: assert property (lookup_valid |=> result_valid)
    else $error("no result after lookup");
  a_result_idle: assert property (!lookup_valid |=> !result_valid)
    else $error("result without lookup");
  a_l5_five: assert property (lookup_valid && !lookup_req.five |=> !result.hit5)
    else $error("level-5 hit outside 5-level paging");
  a_inval_miss: assert property (s_clear |=> !result.hit5 && !result.hit4)
    else $error("hit after invalidation");
  a_alloc_done: assert property (fill_alloc |-> fill_done)
    else $error("alloc pulse without done");
  a_fill_busy: assert property (s_take |=> !fill_ready)
    else $error("fill ready while busy");
  a_fill_bound: assert property (s_take |-> ##[2:100] fill_done)
    else $error("fill never finished");
  a_upd_hold: assert property (upd_valid && !upd_ready |=> upd_valid && $stable(upd))
    else $error("update dropped before taken");
  a_upd_bits: assert property (upd_valid |-> (upd.set_bits & ~64'h0000_0000_0000_0420) == '0)
    else $error("update sets bits other than accessed");
endmodule : upc_top_chk

bind upc_top upc_top_chk u_upc_top_chk (.*);

`default_nettype wire

//--- test/upc_mem_model.sv
// memory side model taking accessed flag updates
`timescale 1ns/1ns
`default_nettype none

module upc_mem_model (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // update channel
  input  wire logic                 upd_valid,
  input  wire upc_pkg::upc_update_t upd,
  output var logic                  upd_ready = 1'b0,
  // observation
  output int                        n_upd = 0,
  output logic [63:0]               last_bits
);
  // ==========================================================
  // random stalls so that held updates are exercised
  always @(posedge aclk) begin
    upd_ready <= aresetn && ($urandom_range(3) == 0);
    if (!aresetn) n_upd <= 0;
    else if (upd_valid && upd_ready) begin
      n_upd <= n_upd + 1;
      last_bits <= upd.set_bits;
    end
  end
endmodule : upc_mem_model

`default_nettype wire

//--- test/tb_upc_top.sv
// self-checking bench for the upper paging cache
`timescale 1ns/1ns
`default_nettype none

module tb_upc_top;
  logic        aclk = '0, aresetn = '0, invalidate = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic        s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, result_valid, fill_ready, fill_done, fill_alloc, upd_valid;
  logic        lookup_valid = '0, fill_valid = '0, upd_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [63:0] last_bits;
  int          n_upd, err_total = 0, num_checks = 0;
  upc_pkg::upc_lookup_t lookup_req = '0;
  upc_pkg::upc_result_t result;
  upc_pkg::upc_fill_t   fill_req = '0;
  upc_pkg::upc_update_t upd;

  upc_top u_upc_top (.*);
  upc_mem_model u_upc_mem_model (.*);
  always #4 aclk = ~aclk;

  // ==========================================================
  // bus and port tasks
  task automatic chk(input logic [63:0] g, input logic [63:0] x, input string m);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] b);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_awvalid || s_axi_wvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  task automatic look(input logic [56:0] ia, input logic five);
    lookup_req <= '{iaddr: ia, kind: upc_pkg::UPC_FIRST, five: five, from_entry: 1'b0};
    lookup_valid <= 1'b1;
    @(posedge aclk);
    lookup_valid <= 1'b0;
    @(posedge aclk);
  endtask : look
  task automatic fill(input upc_pkg::upc_fill_t f, output logic al);
    fill_req <= f;
    fill_valid <= 1'b1;
    do @(posedge aclk); while (fill_ready !== 1'b1);
    fill_valid <= 1'b0;
    do @(posedge aclk); while (fill_done !== 1'b1);
    al = fill_alloc;
  endtask : fill
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // main sequence; expected hits follow the queue of allocated fill indices
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        al;
    logic [63:0] es [4];
    logic [56:0] ia [4];
    int          q5[$], h[$], n0;
    upc_pkg::upc_fill_t f;
    void'($urandom(32'hd63315e2));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, d, r);
    chk(d, 32'h002f_0000, "ctrl reset");
    axr(8'h10, d, r);
    chk(r, 2'h3, "unmapped response");
    axw(8'h10, 32'hffff_ffff, r);
    chk(r, 2'h3, "unmapped write");
    axw(8'h00, 32'h002f_010b, r);
    chk(r, 2'h0, "ctrl write okay");
    axr(8'h00, d, r);
    chk(d, 32'h002f_000b, "ctrl readback");
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      es[i] = ({32'h0, $urandom} << 12) | 64'h7;
      if (i == 1) es[i][7] = 1'b1;
      if (i == 2) es[i][0] = 1'b0;
      if (i == 3) es[i] = es[i] | 64'h8000_0000_0000_0420;
      ia[i] = {9'(i + 5), 48'($urandom)};
      f = '0;
      f.five = 1'b1;
      f.iaddr = ia[i];
      f.e5 = es[i];
      n0 = n_upd;
      fill(f, al);
      chk(al, i == 0 || i == 3, "l5 alloc");
      chk(n_upd - n0, i == 0, "update count");
      if (i == 0 || i == 3) q5.push_back(i);
    end
    chk(last_bits, 64'h420, "accessed bits");
    for (int i = 0; i < 4; i++) begin
      look(ia[i], 1'b1);
      h = q5.find(x) with (x == i);
      chk(result.hit5, h.size() != 0, "l5 hit");
      if (h.size() != 0)
        chk({result.ent5.tab, result.ent5.wr, result.ent5.us, result.ent5.nx},
            {es[i][51:12], es[i][1], es[i][2], es[i][63]}, "l5 fields");
    end
    look(ia[0], 1'b0);
    chk(result.hit5, 1'b0, "l5 under 4-level");
    $display("test 2 done");
    f = '0;
    f.lvl4 = 1'b1;
    f.five = 1'b1;
    f.iaddr = {9'h1f, 9'h0a, 39'($urandom)};
    f.e5 = es[0] | 64'h427;
    f.e4 = ({32'h0, $urandom} << 12) | 64'h8000_0000_0000_0425;
    fill(f, al);
    chk(al, 1'b1, "l4 alloc");
    look(f.iaddr, 1'b1);
    chk({result.hit4, result.ent4.tab, result.ent4.wr, result.ent4.us, result.ent4.nx},
        {1'b1, f.e4[51:12], 3'b011}, "l4 merge");
    look(f.iaddr ^ (57'h1 << 39), 1'b1);
    chk(result.hit4, 1'b0, "l4 tag bit 39");
    for (int k = 0; k < 2; k++) begin
      f.lvl4 = 1'b0;
      f.kind = k ? upc_pkg::UPC_SECOND : upc_pkg::UPC_NESTED;
      f.e5 = k ? es[0] & ~64'h3 : es[0];
      fill(f, al);
      chk(al, 1'b0, "refused fill");
    end
    $display("test 3 done");
    invalidate <= 1'b1;
    @(posedge aclk);
    invalidate <= 1'b0;
    look(ia[0], 1'b1);
    chk(result.hit5, 1'b0, "miss after invalidate");
    axr(8'h04, d, r);
    chk(d, 32'h0, "level counts cleared");
    axr(8'h08, d, r);
    chk(d, 32'h0004_0003, "fill counts");
    axr(8'h0c, d, r);
    chk(d, 32'h0000_0003, "hit count");
    $display("test 4 done");
    give_verdict();
  end

  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : tb_upc_top

`default_nettype wire
